// File: rtl/dcc_channel.sv
// one comparator channel: sampling, change detect, sticky flag
// assumes raw output synchronous to clk_i
`timescale 1ns/100ps
module dcc_channel
    import dcc_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // control
    input  wire logic on_i,
    input  wire logic clear_i,
    // analog side
    input  wire logic raw_i,
    // status
    output logic      sampled_o,
    output logic      flag_o
);
    logic next_sampled;
    logic change;

    assign next_sampled = on_i & raw_i;
    assign change       = next_sampled != sampled_o;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sampled_o <= 1'b0;
            flag_o    <= 1'b0;
        end
        else
        begin
            sampled_o <= next_sampled;
            flag_o    <= change | (flag_o & ~clear_i);
        end
    end

    flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (next_sampled != sampled_o) |=> flag_o)
        else $error("change did not set flag");
    off_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !on_i |=> !sampled_o)
        else $error("sampled output not zero while off");
    clear_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (flag_o && !clear_i && $stable(next_sampled)) |=> flag_o)
        else $error("flag lost without clear");
endmodule

// File: rtl/dcc_model.sv
// behavioural comparator decision for the analog front end view
// assumes voltages arrive as unsigned digital codes
`timescale 1ns/100ps
module dcc_model
    import dcc_pkg::*;
#(
    parameter int W = 12
)
(
    // inputs
    input  wire logic [W-1:0] pos_i,
    input  wire logic [W-1:0] neg_pin_i,
    input  wire logic [W-1:0] bandgap_i,
    input  wire logic         neg_select_i,
    // result
    output logic              out_o
);
    logic [W-1:0] neg;

    assign neg   = neg_select_i ? bandgap_i : neg_pin_i;
    assign out_o = pos_i > neg;
endmodule

// File: rtl/dcc_pkg.sv
// constants, field positions and carrier types of the comparator control
// assumes a 32-bit classic wishbone slave port and two analog comparators
// Operation
// - comparator output is one when positive input exceeds negative, else zero
// - both raw outputs sampled on the clock, shown read-only in status
// - sampled output change sets its flag; irq if its enable set
// - writing one clears a change flag; writing zero leaves it
// - one shared irq formed from flags gated by their enables
// - control bit 1 is the comparator's interrupt enable
// - first comparator bit 4 selects band-gap (1) or its pin (0)
// - second comparator bit 4 selects band-gap (1) or its pin (0)
// - control bit 2 enables hysteresis; off after reset
// - control bit 0 switches the comparator on
// - all registers reset to zero; offsets 0x00, 0x04, 0x08
// - sampled output bits read zero while disabled; bits 3 and 2
// - change flags at status bits 0 and 1, set by hardware
package dcc_pkg;
    localparam logic [3:0]  DCC_CTRL0_OFS  = 4'h0;
    localparam logic [3:0]  DCC_CTRL1_OFS  = 4'h4;
    localparam logic [3:0]  DCC_STAT_OFS   = 4'h8;
    localparam int          DCC_ON_BIT     = 0;
    localparam int          DCC_IE_BIT     = 1;
    localparam int          DCC_HYS_BIT    = 2;
    localparam int          DCC_NSEL_BIT   = 4;
    localparam int          DCC_FLAG_LSB   = 0;
    localparam int          DCC_OUT_LSB    = 2;
    localparam logic [4:0]  DCC_CTRL_RST   = 5'h00;
    localparam logic [31:0] DCC_CTRL_MASK  = 32'h0000_0017;
    localparam int          DCC_STABLE_NS  = 2000;
    localparam int          DCC_CLK_NS     = 10;
    localparam int          DCC_STABLE_CYC =
        (DCC_STABLE_NS + DCC_CLK_NS - 1) / DCC_CLK_NS;

    typedef struct packed {
        logic neg_select;
        logic rsvd;
        logic hysteresis_on;
        logic irq_enable;
        logic on;
    } dcc_ctrl_t;

    typedef struct packed {
        logic neg_select;
        logic hysteresis_on;
        logic on;
    } dcc_analog_t;
endpackage

// File: rtl/dcc_top.sv
// wishbone register file and control of two comparators
// assumes synchronous raw comparator outputs or digitised input levels
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/100ps
module dcc_top
    import dcc_pkg::*;
#(
    parameter int W = 12
)
(
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // wishbone slave
    input  wire logic         cyc_i,
    input  wire logic         stb_i,
    input  wire logic         we_i,
    input  wire logic [3:0]   adr_i,
    input  wire logic [3:0]   sel_i,
    input  wire logic [31:0]  dat_i,
    output logic      [31:0]  dat_o,
    output logic              ack_o,
    // analog inputs as codes
    input  wire logic [W-1:0] a_pos_i,
    input  wire logic [W-1:0] cmp_a_neg_pin_i,
    input  wire logic [W-1:0] b_pos_i,
    input  wire logic [W-1:0] cmp_b_neg_pin_i,
    input  wire logic [W-1:0] bandgap_i,
    // analog controls
    output dcc_analog_t       cmp_a_ctl_o,
    output dcc_analog_t       cmp_b_ctl_o,
    // interrupt
    output logic              irq_o
);
    // refuse code widths the compare path cannot serve
    if (W < 1 || W > 32)
    begin : gen_bad_w
        $error("dcc_top: W out of range");
    end

    dcc_ctrl_t   ctrl [2];
    logic [1:0]  raw;
    logic [1:0]  sampled;
    logic [1:0]  flag;
    logic [1:0]  clear;
    logic [1:0]  ie;
    logic        access;
    logic        wr_en;
    logic        hit_c0;
    logic        hit_c1;
    logic        hit_st;
    logic [31:0] stat_word;
    logic [31:0] next_dat;
    logic        next_irq;

    // bus decode, answered one cycle after request
    assign access  = cyc_i & stb_i & ~ack_o;
    assign wr_en   = access & we_i & sel_i[0];
    assign hit_c0  = adr_i == DCC_CTRL0_OFS;
    assign hit_c1  = adr_i == DCC_CTRL1_OFS;
    assign hit_st  = adr_i == DCC_STAT_OFS;

    assign stat_word = {28'h0000000, sampled, flag};
    assign next_dat  = hit_c0 ? {27'h0000000, ctrl[0]} :
                       hit_c1 ? {27'h0000000, ctrl[1]} :
                       hit_st ? stat_word : 32'h0000_0000;

    assign next_irq = |(flag & ie);

    dcc_model #(.W(W)) u_cmp_a (
        .pos_i        (a_pos_i),
        .neg_pin_i    (cmp_a_neg_pin_i),
        .bandgap_i    (bandgap_i),
        .neg_select_i (ctrl[0].neg_select),
        .out_o        (raw[0])
    );
    dcc_model #(.W(W)) u_cmp_b (
        .pos_i        (b_pos_i),
        .neg_pin_i    (cmp_b_neg_pin_i),
        .bandgap_i    (bandgap_i),
        .neg_select_i (ctrl[1].neg_select),
        .out_o        (raw[1])
    );

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_ch
            assign ie[g]    = ctrl[g].irq_enable;
            assign clear[g] = wr_en & hit_st & dat_i[DCC_FLAG_LSB + g];
            dcc_channel u_ch (
                .clk_i     (clk_i),
                .rst_i     (rst_i),
                .on_i      (ctrl[g].on),
                .clear_i   (clear[g]),
                .raw_i     (raw[g]),
                .sampled_o (sampled[g]),
                .flag_o    (flag[g])
            );
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl[0] <= DCC_CTRL_RST;
            ctrl[1] <= DCC_CTRL_RST;
        end
        else
        begin
            if (wr_en && hit_c0)
                ctrl[0] <= dat_i[4:0] & DCC_CTRL_MASK[4:0];
            if (wr_en && hit_c1)
                ctrl[1] <= dat_i[4:0] & DCC_CTRL_MASK[4:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o       <= 1'b0;
            dat_o       <= 32'h0000_0000;
            irq_o       <= 1'b0;
            cmp_a_ctl_o <= '0;
            cmp_b_ctl_o <= '0;
        end
        else
        begin
            ack_o       <= access;
            dat_o       <= access ? next_dat : 32'h0000_0000;
            irq_o       <= next_irq;
            cmp_a_ctl_o <= {ctrl[0].neg_select, ctrl[0].hysteresis_on,
                            ctrl[0].on};
            cmp_b_ctl_o <= {ctrl[1].neg_select, ctrl[1].hysteresis_on,
                            ctrl[1].on};
        end
    end

    ack_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
        else $error("ack not single cycle");
    irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (flag[0] && ie[0]) |=> irq_o)
        else $error("enabled flag did not raise irq");
    irq_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(|(flag & ie)) |=> !irq_o)
        else $error("irq without enabled flag");
    hys_reset_a: assert property (@(posedge clk_i)
        $past(rst_i) |-> !cmp_a_ctl_o.hysteresis_on)
        else $error("hysteresis on after reset");
    sel_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |->
        cmp_b_ctl_o.neg_select == $past(ctrl[1].neg_select))
        else $error("select not driven out");
    rdat_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    irq_gate_b_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (flag[1] && ie[1]) |=> irq_o)
        else $error("enabled flag b did not raise irq");
endmodule

// File: test/dcc_front_model.sv
// partner: two analog comparators and their input pins, as codes
// assumes the bench picks the wanted sign of each comparison
`timescale 1ns/100ps
module dcc_front_model
    import dcc_pkg::*;
#(
    parameter int W = 12
)
(
    // wanted sign: 0 below, 1 equal, 2 above the chosen reference
    input  wire logic [1:0]   a_mode_i,
    input  wire logic [1:0]   b_mode_i,
    // source choices from the block
    input  wire dcc_analog_t  a_ctl_i,
    input  wire dcc_analog_t  b_ctl_i,
    // input pins
    output logic      [W-1:0] a_pos_o,
    output logic      [W-1:0] a_neg_o,
    output logic      [W-1:0] b_pos_o,
    output logic      [W-1:0] b_neg_o,
    output logic      [W-1:0] bg_o
);
    // pins and band-gap far apart so a wrong source shows
    assign a_neg_o = W'(12'h800);
    assign b_neg_o = W'(12'h800);
    assign bg_o    = W'(12'h400);
    assign a_pos_o = (a_ctl_i.neg_select ? bg_o : a_neg_o)
                     + W'(a_mode_i) - 1'b1;
    assign b_pos_o = (b_ctl_i.neg_select ? bg_o : b_neg_o)
                     + W'(b_mode_i) - 1'b1;
endmodule

// File: test/testbench.sv
// testbench: register level tests of the comparator control
// assumes the analog side comes from the partner model
`timescale 1ns/100ps
module testbench
    import dcc_pkg::*;
;
    logic         clk_i, rst_i, cyc, stb, we, ack, irq;
    logic [3:0]   adr, sel, wsel;
    logic [31:0]  wdat, rdat, q;
    logic [11:0]  a_pos, a_neg, b_pos, b_neg, bg;
    logic [1:0]   a_mode, b_mode;
    dcc_analog_t  a_ctl, b_ctl;
    int           fail_count, cmp_count;

    dcc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
        .ack_o(ack), .a_pos_i(a_pos), .cmp_a_neg_pin_i(a_neg),
        .b_pos_i(b_pos), .cmp_b_neg_pin_i(b_neg), .bandgap_i(bg),
        .cmp_a_ctl_o(a_ctl), .cmp_b_ctl_o(b_ctl), .irq_o(irq));
    dcc_front_model partner (.a_mode_i(a_mode), .b_mode_i(b_mode),
        .a_ctl_i(a_ctl), .b_ctl_i(b_ctl), .a_pos_o(a_pos),
        .a_neg_o(a_neg), .b_pos_o(b_pos), .b_neg_o(b_neg), .bg_o(bg));

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= wsel;
        adr <= a;
        wdat <= d;
        do
            @(posedge clk_i);
        while (ack !== 1'b1 && n++ < 20);
        q = rdat;
        chk(32'(ack), 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic settle;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        finish_test;
    end
    initial
    begin
        rst_i = 1'b1;
        {cyc, stb, we, adr, wdat} = '0;
        sel = 4'h0;
        wsel = 4'hf;
        a_mode = 2'd2;
        b_mode = 2'd0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h0);
        rd(4'hc, 32'h0);
        $display("test reset done");
        wr(4'h0, 32'h17);
        wr(4'h4, 32'h16);
        rd(4'h0, 32'h17);
        rd(4'h4, 32'h16);
        repeat (DCC_STABLE_CYC) @(posedge clk_i);
        chk(32'(a_ctl), 32'h7);
        chk(32'(b_ctl), 32'h6);
        rd(4'h8, 32'h5);
        chk(32'(irq), 32'h1);
        $display("test enable done");
        wr(4'h8, 32'h0);
        rd(4'h8, 32'h5);
        wr(4'h8, 32'h1);
        rd(4'h8, 32'h4);
        chk(32'(irq), 32'h0);
        a_mode <= 2'd1;
        settle;
        rd(4'h8, 32'h1);
        chk(32'(irq), 32'h1);
        $display("test clear done");
        wr(4'h0, 32'h15);
        wr(4'h8, 32'h1);
        wr(4'h4, 32'h3);
        a_mode <= 2'd2;
        settle;
        rd(4'h8, 32'h5);
        chk(32'(irq), 32'h0);
        b_mode <= 2'd2;
        settle;
        rd(4'h8, 32'hf);
        chk(32'(irq), 32'h1);
        $display("test sources done");
        // output change lands on the same edge as the clearing write
        fork
            wr(4'h8, 32'h1);
            begin
                @(posedge clk_i);
                a_mode <= 2'd0;
            end
        join
        rd(4'h8, 32'hb);
        a_mode <= 2'd2;
        settle;
        $display("test collide done");
        wr(4'h8, 32'h3);
        wr(4'h0, 32'h0);
        settle;
        rd(4'h8, 32'h9);
        $display("test disable done");
        wsel = 4'he;
        wr(4'h0, 32'h17);
        wsel = 4'hf;
        rd(4'h0, 32'h0);
        wr(4'hc, 32'h17);
        rd(4'hc, 32'h0);
        rd(4'h4, 32'h3);
        $display("test refuse done");
        finish_test;
    end
endmodule
